// ==== include/hv_seq_defs.svh ====
// register offsets, reset values, field positions and timing for the sequencer
`ifndef HV_SEQ_DEFS_SVH
`define HV_SEQ_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (7-bit serial-port address)
// ----------------------------------------------------------------------
`define REG_FAST_CTRL 7'h01
`define REG_SEQ_CMD 7'h02
`define REG_SEQ_STAT 7'h03
`define REG_FAULT_DLY 7'h0F
`define REG_OFS_DUR 7'h10
`define REG_BIAS_DUR 7'h11

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define FAST_CTRL_RST 8'h01
`define FAULT_DLY_RST 8'h07
`define OFS_DUR_RST 8'h01
`define BIAS_DUR_RST 8'h01
`define FAST_EN_BIT 0
`define CMD_SOFT_OFF_BIT 0
`define STOP_DLY_LSB 0
`define DIS_DLY_LSB 4
`define SPI_WRITE_BIT 7

// ----------------------------------------------------------------------
// timing: clock, delay tick and fixed sequence delays
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define TICK_NS 4000
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
`define DUR_UNIT_US 1000
`define NORM_STOP_US 10000
`define RESETZ_DIS_US 1000
`define LV_SETTLE_US 1000
`define DISCHARGE_US 1000
`define US_TO_TICKS(us) (((us) * 1000 + `TICK_NS - 1) / `TICK_NS)
`define MAX_DLY_CODE 4'h8

`endif

// ==== include/hv_seq_pkg.sv ====
// types shared by the rail sequencer and its delay timer
package hv_seq_pkg;

  // one control bit per high-voltage rail
  typedef struct packed {
    logic offset;
    logic bias;
    logic reset;
  } rail_ctl_t;

  // serial-port pin group after synchronisation
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spi_pins_t;

  // sequencer states, one-hot
  typedef enum logic [11:0] {
    ST_OFF      = 12'h001,
    ST_LV_UP    = 12'h002,
    ST_OFS_UP   = 12'h004,
    ST_BIAS_UP  = 12'h008,
    ST_READY    = 12'h010,
    ST_N_STOP   = 12'h020,
    ST_N_RESET  = 12'h040,
    ST_DISCH    = 12'h080,
    ST_F_STOP   = 12'h100,
    ST_F_DIS    = 12'h200,
    ST_STANDBY  = 12'h400,
    ST_RESTART  = 12'h800
  } seq_state_t;

endpackage

// ==== hw/delay_timer.sv ====
// down-counter that measures sequence delays in ticks of the delay clock
`timescale 1ns/1ps
module delay_timer
  import hv_seq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // control
  input wire logic tick_en,
  input wire logic start,
  input wire logic [15:0] load,
  // result
  output logic done
);

  logic [15:0] cnt_r;
  logic busy_r;

  // start reloads even while busy so a new state always gets a full delay
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      busy_r <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_r <= (load == 16'h0000) ? 16'h0001 : load;
      busy_r <= 1'b1;
      done <= 1'b0;
    end else if (busy_r && tick_en) begin
      cnt_r <= cnt_r - 16'h0001;
      busy_r <= (cnt_r != 16'h0001);
      done <= (cnt_r == 16'h0001);
    end else begin
      done <= 1'b0;
    end
  end

endmodule // delay_timer

// ==== hw/hv_rail_power_sequencer.sv ====
// high-voltage rail power sequencer with serial-port register file
`timescale 1ns/1ps
`include "hv_seq_defs.svh"

// What this block does
// RULE1: Input supply below undervoltage threshold starts shutdown handling at once.
// RULE2: Power request high: low-voltage supplies first, then three rails, then ready.
// RULE3: Offset rail, wait 0x10 duration, bias rail, wait 0x11 duration, reset rail.
// RULE4: Request low: stop bias and reset; 10 ms later stop offset, reset low.
// RULE5: 1 ms after system reset low, discharge rails, then drop all supplies.
// RULE6: Normal shutdown without fault keeps fault interrupt high.
// RULE7: Fault asserts fault interrupt and selects fast shutdown.
// RULE8: Register 0x01 bit enables fast shutdown; enabled after reset.
// RULE9: Fault to bias/reset stop delay from 0x0F field, 4 us to 1.1 ms; the code tops out at 1024 us.
// RULE10: Second 0x0F delay, then discharge rails and pull system reset low.
// RULE11: Fast shutdown ends by dropping internal high-voltage domain enable.
// RULE12: Standby while fault persists; on clear, third supply then normal startup.
// RULE13: State machine chains steps itself; other steps come by serial command.
// RULE14: Delays counted on internal clock with a 4 us resolution tick.
module hv_rail_power_sequencer
  import hv_seq_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYC
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // request and monitoring inputs (asynchronous pins)
  input wire logic power_on_request,
  input wire logic uvlo_low,
  input wire logic fault_detect,
  // serial port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // supply controls
  output logic lv_supply_en,
  output logic third_supply,
  output logic hv_domain_enable,
  output rail_ctl_t rail_regulate,
  output rail_ctl_t rail_discharge,
  // system outputs
  output logic sys_reset_n,
  output logic fault_int_n
);

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic sclk_d_r;
  spi_pins_t pin_s;
  logic req_s;
  logic uvlo_s;
  logic fault_s;

  // two flops per pin; only the second stage feeds logic
  // chip select resets to its idle high so no frame starts after reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1_r <= 6'h02;
      sync2_r <= 6'h02;
    end else begin
      sync1_r <= {fault_detect, uvlo_low, power_on_request,
                  spi_sclk, spi_cs_n, spi_mosi};
      sync2_r <= sync1_r;
    end
  end

  assign pin_s = spi_pins_t'(sync2_r[2:0]);
  assign req_s = sync2_r[3];
  assign uvlo_s = sync2_r[4];
  assign fault_s = sync2_r[5];

  // --------------------------------------------------------------------
  // serial-port slave: 16-bit frames, mode 0
  // --------------------------------------------------------------------
  logic sclk_rise;
  logic sclk_fall;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_in_r;
  logic [7:0] cmd_r;
  logic [7:0] sh_out_r;
  logic wr_stb;
  logic [7:0] rdata;

  // sclk edges seen through the synchroniser; sclk must stay slow
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= pin_s.sclk;
    end
  end

  assign sclk_rise = pin_s.sclk & ~sclk_d_r & ~pin_s.cs_n;
  assign sclk_fall = ~pin_s.sclk & sclk_d_r & ~pin_s.cs_n;
  assign wr_stb = sclk_rise && (bit_cnt_r == 4'hF) &&
                  cmd_r[`SPI_WRITE_BIT];

  // shift in address byte then data byte
  always_ff @(posedge mclk) begin
    if (!rstn || pin_s.cs_n) begin
      bit_cnt_r <= 4'h0;
      sh_in_r <= 8'h00;
      cmd_r <= 8'h00;
    end else if (sclk_rise) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      sh_in_r <= {sh_in_r[6:0], pin_s.mosi};
      if (bit_cnt_r == 4'h7) begin
        cmd_r <= {sh_in_r[6:0], pin_s.mosi};
      end
    end
  end

  // read data is captured after the address byte and shifted on falls
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sh_out_r <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= ~pin_s.cs_n;
      if (sclk_fall && bit_cnt_r == 4'h8) begin
        spi_miso <= rdata[7];
        sh_out_r <= {rdata[6:0], 1'b0};
      end else if (sclk_fall && bit_cnt_r > 4'h8) begin
        spi_miso <= sh_out_r[7];
        sh_out_r <= {sh_out_r[6:0], 1'b0};
      end
    end
  end

  // --------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------
  logic [7:0] fast_ctrl_r;
  logic [7:0] fault_dly_r;
  logic [7:0] ofs_dur_r;
  logic [7:0] bias_dur_r;
  logic soft_off_r;
  logic fault_lat_r;
  logic [6:0] waddr;
  logic [7:0] wdata;
  seq_state_t state_r;
  seq_state_t state_nxt;

  assign waddr = cmd_r[6:0];
  assign wdata = {sh_in_r[6:0], pin_s.mosi};

  // writable registers; fast shutdown comes out of reset enabled
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fast_ctrl_r <= `FAST_CTRL_RST; // RULE8
      fault_dly_r <= `FAULT_DLY_RST;
      ofs_dur_r <= `OFS_DUR_RST;
      bias_dur_r <= `BIAS_DUR_RST;
    end else if (wr_stb) begin
      if (waddr == `REG_FAST_CTRL) begin
        fast_ctrl_r <= wdata; // RULE8
      end else if (waddr == `REG_FAULT_DLY) begin
        fault_dly_r <= wdata;
      end else if (waddr == `REG_OFS_DUR) begin
        ofs_dur_r <= wdata;
      end else if (waddr == `REG_BIAS_DUR) begin
        bias_dur_r <= wdata;
      end
    end
  end

  // soft power-off command: sticky until the sequence is off with the request pin low
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      soft_off_r <= 1'b0;
    end else if (wr_stb && waddr == `REG_SEQ_CMD) begin
      soft_off_r <= wdata[`CMD_SOFT_OFF_BIT]; // RULE13
    end else if (state_r == ST_OFF && !req_s) begin
      soft_off_r <= 1'b0;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    if (cmd_r[6:0] == `REG_FAST_CTRL) begin
      rdata = fast_ctrl_r;
    end else if (cmd_r[6:0] == `REG_SEQ_CMD) begin
      rdata = {7'h00, soft_off_r};
    end else if (cmd_r[6:0] == `REG_SEQ_STAT) begin
      rdata = {fault_lat_r, fault_s, state_r == ST_READY, hv_domain_enable,
               sys_reset_n, rail_regulate};
    end else if (cmd_r[6:0] == `REG_FAULT_DLY) begin
      rdata = fault_dly_r;
    end else if (cmd_r[6:0] == `REG_OFS_DUR) begin
      rdata = ofs_dur_r;
    end else if (cmd_r[6:0] == `REG_BIAS_DUR) begin
      rdata = bias_dur_r;
    end else begin
      rdata = 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // delay tick and timer
  // --------------------------------------------------------------------
  logic [15:0] div_r;
  logic tick_r;
  logic tmr_start;
  logic tmr_done;
  logic [15:0] tmr_load;

  // one-cycle tick every 4 us; all sequence delays count these
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == 16'(TICK_CYCLES - 1)); // RULE14
      div_r <= (div_r == 16'(TICK_CYCLES - 1)) ? 16'h0000 : div_r + 16'h0001;
    end
  end

  // programmable fault delays: 4 us times a power of two, up to 1024 us
  function automatic logic [15:0] code_ticks(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `MAX_DLY_CODE) ? `MAX_DLY_CODE : code;
    return 16'h0001 << c;
  endfunction

  // delay for the state about to be entered
  always_comb begin
    case (state_nxt)
      ST_LV_UP: tmr_load = 16'(`US_TO_TICKS(`LV_SETTLE_US)); // RULE2
      ST_OFS_UP: tmr_load = 16'(ofs_dur_r) *
                            16'(`US_TO_TICKS(`DUR_UNIT_US)); // RULE3
      ST_BIAS_UP: tmr_load = 16'(bias_dur_r) *
                             16'(`US_TO_TICKS(`DUR_UNIT_US)); // RULE3
      ST_N_STOP: tmr_load = 16'(`US_TO_TICKS(`NORM_STOP_US)); // RULE4
      ST_N_RESET: tmr_load = 16'(`US_TO_TICKS(`RESETZ_DIS_US)); // RULE5
      ST_DISCH: tmr_load = 16'(`US_TO_TICKS(`DISCHARGE_US));
      ST_F_STOP: tmr_load = code_ticks(fault_dly_r[`STOP_DLY_LSB +: 4]); // RULE9
      ST_F_DIS: tmr_load = code_ticks(fault_dly_r[`DIS_DLY_LSB +: 4]); // RULE10
      default: tmr_load = 16'h0001;
    endcase
  end

  assign tmr_start = (state_nxt != state_r);

  delay_timer u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .tick_en(tick_r),
    .start(tmr_start),
    .load(tmr_load),
    .done(tmr_done)
  );

  // --------------------------------------------------------------------
  // sequencing state machine
  // --------------------------------------------------------------------
  logic fault_ev;
  logic fast_en;
  logic off_req;

  // undervoltage counts as a fault: the supply is about to vanish
  assign fault_ev = fault_s | uvlo_s; // RULE1
  assign fast_en = fast_ctrl_r[`FAST_EN_BIT]; // RULE8
  assign off_req = ~req_s | soft_off_r;

  // fault latch: set wins over the clear at restart
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fault_lat_r <= 1'b0;
    end else if (fault_ev) begin
      fault_lat_r <= 1'b1; // RULE7
    end else if (state_r == ST_RESTART) begin
      fault_lat_r <= 1'b0; // RULE12
    end
  end

  // next state; the machine chains each timed step itself
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (req_s && !soft_off_r && !fault_ev) state_nxt = ST_LV_UP; // RULE2
      end
      ST_LV_UP, ST_OFS_UP, ST_BIAS_UP, ST_READY: begin
        if (fault_ev && fast_en) begin
          state_nxt = ST_F_STOP; // RULE7
        end else if (off_req || fault_ev) begin
          state_nxt = ST_N_STOP; // RULE4
        end else if (tmr_done && state_r == ST_LV_UP) begin
          state_nxt = ST_OFS_UP; // RULE2
        end else if (tmr_done && state_r == ST_OFS_UP) begin
          state_nxt = ST_BIAS_UP; // RULE3
        end else if (tmr_done && state_r == ST_BIAS_UP) begin
          state_nxt = ST_READY; // RULE3
        end
      end
      ST_N_STOP: begin
        if (fault_ev && fast_en) state_nxt = ST_F_STOP;
        else if (tmr_done) state_nxt = ST_N_RESET; // RULE4
      end
      ST_N_RESET: begin
        if (tmr_done) state_nxt = ST_DISCH; // RULE5
      end
      ST_DISCH: begin
        if (tmr_done) state_nxt = fault_lat_r ? ST_STANDBY : ST_OFF; // RULE5
      end
      ST_F_STOP: begin
        if (tmr_done) state_nxt = ST_F_DIS; // RULE9
      end
      ST_F_DIS: begin
        if (tmr_done) state_nxt = ST_DISCH; // RULE10
      end
      ST_STANDBY: begin
        if (!fault_ev) state_nxt = req_s ? ST_RESTART : ST_OFF; // RULE12
      end
      ST_RESTART: state_nxt = ST_LV_UP; // RULE12
      default: state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------------
  // registered outputs, decoded from the next state; fault interrupt from the fault latch or the live fault event
  // --------------------------------------------------------------------
  // regulate flags follow the power-up order and drop in shutdown order
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rail_regulate <= '0;
      rail_discharge <= '0;
    end else begin
      // the fast-shutdown states only hold rails that were already on, never start one
      rail_regulate.offset <= (state_nxt inside {ST_OFS_UP, ST_BIAS_UP,
                               ST_READY, ST_N_STOP}) ||
                              (state_nxt inside {ST_F_STOP, ST_F_DIS} &&
                               rail_regulate.offset); // RULE3
      rail_regulate.bias <= (state_nxt inside {ST_BIAS_UP, ST_READY}) ||
                            (state_nxt == ST_F_STOP &&
                             rail_regulate.bias); // RULE4 RULE9
      rail_regulate.reset <= (state_nxt == ST_READY) ||
                             (state_nxt == ST_F_STOP &&
                              rail_regulate.reset); // RULE3 RULE9
      rail_discharge <= (state_nxt == ST_DISCH) ?
                        3'b111 : 3'b000; // RULE5 RULE10
    end
  end

  // supplies, domain enable, system reset and fault interrupt
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lv_supply_en <= 1'b0;
      third_supply <= 1'b0;
      hv_domain_enable <= 1'b0;
      sys_reset_n <= 1'b0;
      fault_int_n <= 1'b1;
    end else begin
      lv_supply_en <= !(state_nxt inside {ST_OFF, ST_STANDBY}); // RULE5
      third_supply <= !(state_nxt inside {ST_OFF, ST_STANDBY}); // RULE12
      hv_domain_enable <= !(state_nxt inside {ST_OFF, ST_STANDBY,
                            ST_RESTART}); // RULE11
      sys_reset_n <= state_nxt inside {ST_LV_UP, ST_OFS_UP, ST_BIAS_UP,
                     ST_READY, ST_N_STOP, ST_F_STOP,
                     ST_F_DIS}; // RULE4 RULE10
      fault_int_n <= !(fault_lat_r || fault_ev); // RULE6 RULE7
    end
  end

endmodule // hv_rail_power_sequencer

// ==== testbench/hv_seq_chk.sv ====
// port checker for the rail sequencer
`timescale 1ns/1ps
module hv_seq_chk
  import hv_seq_pkg::*;
#(
  parameter int TICK_CYCLES = 2
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // inputs
  input wire logic power_on_request,
  input wire logic uvlo_low,
  input wire logic fault_detect,
  input wire logic spi_cs_n,
  // outputs
  input wire logic spi_miso_oe,
  input wire logic lv_supply_en,
  input wire logic hv_domain_enable,
  input wire rail_ctl_t rail_regulate,
  input wire rail_ctl_t rail_discharge,
  input wire logic sys_reset_n,
  input wire logic fault_int_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  chk_uvlo_int: assert property (
    $rose(uvlo_low) && hv_domain_enable |-> ##[1:6] !fault_int_n)
    else $error("no interrupt after undervoltage");
  chk_fault_int: assert property (
    $rose(fault_detect) && hv_domain_enable |-> ##[1:6] !fault_int_n)
    else $error("no interrupt after fault");
  // the interrupt only falls with a cause seen a few cycles before
  chk_int_cause: assert property (
    $fell(fault_int_n) |-> $past(fault_detect, 2) || $past(uvlo_low, 2))
    else $error("interrupt without fault");
  chk_ofs_first: assert property (
    $rose(rail_regulate.bias) |-> rail_regulate.offset && !rail_regulate.reset)
    else $error("bias rail out of order");
  chk_lv_first: assert property (
    rail_regulate != 3'b000 |-> lv_supply_en && hv_domain_enable)
    else $error("rail on without supplies");
  chk_no_fight: assert property (
    (rail_regulate & rail_discharge) == 3'b000)
    else $error("rail regulated and discharged");
  chk_ofs_last: assert property (
    $fell(rail_regulate.offset) |-> rail_regulate == 3'b000 && !sys_reset_n)
    else $error("offset rail stopped early");
  chk_dis_reset: assert property (
    $rose(rail_discharge.offset) |-> !sys_reset_n && rail_discharge == 3'b111)
    else $error("discharge with reset high");
  chk_hvdom_last: assert property (
    $fell(hv_domain_enable) |-> !sys_reset_n && rail_regulate == 3'b000)
    else $error("domain dropped too soon");
  chk_miso_rel: assert property (
    spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("serial out driven while idle");
endmodule // hv_seq_chk

bind hv_rail_power_sequencer hv_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .mclk(mclk), .rstn(rstn), .power_on_request(power_on_request),
  .uvlo_low(uvlo_low), .fault_detect(fault_detect), .spi_cs_n(spi_cs_n),
  .spi_miso_oe(spi_miso_oe), .lv_supply_en(lv_supply_en),
  .hv_domain_enable(hv_domain_enable), .rail_regulate(rail_regulate),
  .rail_discharge(rail_discharge), .sys_reset_n(sys_reset_n),
  .fault_int_n(fault_int_n));

// ==== testbench/ctrl_model.sv ====
// serial-port controller model that sends register frames
`timescale 1ns/1ps
module ctrl_model (
  // clock
  input wire logic mclk,
  // serial port
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  localparam int HALF = 6; // half period, above the 3-cycle sync need
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end
  // one 16-bit mode-0 frame, msb first; data read at each rising sclk of the data byte
  task automatic xfer(input logic wr, input logic [6:0] addr,
                      input logic [7:0] wdat, output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {wr, addr, wdat};
    rdat = 8'h00;
    @(posedge mclk);
    spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi <= sh[i];
      repeat (HALF) @(posedge mclk);
      spi_sclk <= 1'b1;
      if (i < 8)
        rdat = {rdat[6:0], spi_miso};
      repeat (HALF) @(posedge mclk);
      spi_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge mclk);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~sh[0]; // released line must not keep a usable value
    repeat (4 * HALF) @(posedge mclk);
  endtask
endmodule // ctrl_model

// ==== testbench/tb.sv ====
// self-checking bench for the high-voltage rail sequencer
`timescale 1ns/1ps
`include "hv_seq_defs.svh"
module tb;
  import hv_seq_pkg::*;
  localparam int TICKC = 2; // short tick keeps the run brief
  localparam int MS = 250 * TICKC;
  localparam int TOL = 8; // one tick plus sync and register lag
  localparam int LIMIT = 60000;
  typedef struct {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } row_t;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic power_on_request = 1'b0;
  logic uvlo_low = 1'b0;
  logic fault_detect = 1'b0;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic lv_supply_en, third_supply, hv_domain_enable, sys_reset_n, fault_int_n;
  rail_ctl_t rail_regulate, rail_discharge;
  logic [7:0] rd;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int t_ev, t_lv, t_ofs, t_bias, t_rst, t_bias_off, t_ofs_off, t_srl;
  int t_dis, t_int, t_third, t_hv_off;
  // reads give the expected data, writes give the data sent
  row_t rows [12] = '{
    '{1'b0, `REG_FAST_CTRL, `FAST_CTRL_RST},
    '{1'b0, `REG_FAULT_DLY, `FAULT_DLY_RST},
    '{1'b0, `REG_OFS_DUR, `OFS_DUR_RST}, '{1'b0, `REG_BIAS_DUR, `BIAS_DUR_RST},
    '{1'b1, `REG_OFS_DUR, 8'h02}, '{1'b1, `REG_BIAS_DUR, 8'h03},
    '{1'b1, `REG_FAULT_DLY, 8'h32}, '{1'b1, 7'h7F, 8'hAA},
    '{1'b0, 7'h7F, 8'h00}, '{1'b0, `REG_OFS_DUR, 8'h02},
    '{1'b0, `REG_BIAS_DUR, 8'h03}, '{1'b0, `REG_FAULT_DLY, 8'h32}};

  always #10 mclk = ~mclk;

  hv_rail_power_sequencer #(.TICK_CYCLES(TICKC)) dut_u (
    .mclk(mclk), .rstn(rstn), .power_on_request(power_on_request),
    .uvlo_low(uvlo_low), .fault_detect(fault_detect), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .lv_supply_en(lv_supply_en),
    .third_supply(third_supply), .hv_domain_enable(hv_domain_enable),
    .rail_regulate(rail_regulate), .rail_discharge(rail_discharge),
    .sys_reset_n(sys_reset_n), .fault_int_n(fault_int_n));

  ctrl_model ctrl_u (.mclk(mclk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  // edge time stamps of the outputs, in clock cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if ($rose(lv_supply_en)) t_lv <= cyc;
    if ($rose(rail_regulate.offset)) t_ofs <= cyc;
    if ($rose(rail_regulate.bias)) t_bias <= cyc;
    if ($rose(rail_regulate.reset)) t_rst <= cyc;
    if ($fell(rail_regulate.bias)) t_bias_off <= cyc;
    if ($fell(rail_regulate.offset)) t_ofs_off <= cyc;
    if ($fell(sys_reset_n)) t_srl <= cyc;
    if ($rose(rail_discharge.offset)) t_dis <= cyc;
    if ($fell(fault_int_n)) t_int <= cyc;
    if ($rose(third_supply)) t_third <= cyc;
    if ($fell(hv_domain_enable)) t_hv_off <= cyc;
    if (cyc == LIMIT) begin
      n_mismatch++;
      $display("unexpected at %0t: run hung", $time);
      summarize();
    end
  end

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("unexpected at %0t: span %0d not %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // bounded wait for one output event; two spare edges settle stamps
  task automatic wait_for(input int which, input int lim);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge mclk);
      case (which)
        0: hit = rail_regulate.reset === 1'b1;
        2: hit = hv_domain_enable === 1'b0;
        default: hit = rail_discharge.offset === 1'b1;
      endcase
    end
    if (!hit)
      chk_span(-1, 0, 0);
    repeat (2) @(posedge mclk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (rows[i]) begin
      ctrl_u.xfer(rows[i].wr, rows[i].addr, rows[i].data, rd);
      if (!rows[i].wr)
        chk_val(rd, rows[i].data);
    end
    // power up with 2 ms and 3 ms state durations
    power_on_request <= 1'b1;
    wait_for(0, 8 * MS);
    chk_span(t_ofs - t_lv, MS - TOL, MS + TOL);
    chk_span(t_bias - t_ofs, 2 * MS - TOL, 2 * MS + TOL);
    chk_span(t_rst - t_bias, 3 * MS - TOL, 3 * MS + TOL);
    // normal shutdown, no fault
    power_on_request <= 1'b0;
    wait_for(4, 12 * MS);
    chk_span(t_ofs_off - t_bias_off, 10 * MS - TOL, 10 * MS + TOL);
    chk_span(t_srl - t_ofs_off, 0, 2);
    chk_span(t_dis - t_srl, MS - TOL, MS + TOL);
    chk_val({7'h00, fault_int_n}, 8'h01);
    repeat (2 * MS) @(posedge mclk);
    chk_val({7'h00, lv_supply_en}, 8'h00);
    // undervoltage while ready: fast path, 4 and 8 tick delays
    power_on_request <= 1'b1;
    wait_for(0, 8 * MS);
    uvlo_low <= 1'b1;
    t_ev = cyc;
    wait_for(2, 2 * MS);
    chk_span(t_int - t_ev, 1, TOL);
    chk_span(t_bias_off - t_ev, 4 * TICKC, 4 * TICKC + TOL);
    chk_span(t_dis - t_bias_off, 8 * TICKC, 8 * TICKC + TOL);
    chk_span(t_srl - t_dis, -2, 2);
    chk_span(t_hv_off - t_dis, 0, 2 * MS);
    // standby while the cause holds, restart once it clears
    repeat (400) @(posedge mclk);
    chk_val({7'h00, lv_supply_en}, 8'h00);
    uvlo_low <= 1'b0;
    t_ev = cyc;
    wait_for(0, 8 * MS);
    chk_span(t_third - t_ev, 1, TOL);
    chk_span(t_ofs - t_third, MS - TOL, MS + TOL);
    // fast path off: a fault takes the slow order
    ctrl_u.xfer(1'b1, `REG_FAST_CTRL, 8'h00, rd);
    fault_detect <= 1'b1;
    t_ev = cyc;
    wait_for(4, 12 * MS);
    chk_span(t_ofs_off - t_bias_off, 10 * MS - TOL, 10 * MS + TOL);
    chk_span(t_int - t_ev, 1, TOL);
    fault_detect <= 1'b0;
    wait_for(0, 8 * MS);
    chk_val({7'h00, fault_int_n}, 8'h01);
    // serial soft power-off while the request pin stays high
    ctrl_u.xfer(1'b1, `REG_SEQ_CMD, 8'h01, rd);
    wait_for(4, 12 * MS);
    chk_span(t_ofs_off - t_bias_off, 10 * MS - TOL, 10 * MS + TOL);
    repeat (2 * MS) @(posedge mclk);
    chk_val({7'h00, lv_supply_en}, 8'h00);
    summarize();
  end
endmodule // tb
